//--- core/spi_flash_params.svh
// Constants for the serial flash status and identification command block.
`ifndef SPI_FLASH_PARAMS_SVH
`define SPI_FLASH_PARAMS_SVH

// Fixed opcodes.
`define SF_OP_WRITE_DISABLE 8'h04
`define SF_OP_STATUS_READ   8'h05
`define SF_OP_JEDEC_ID      8'h9F
`define SF_OP_LEGACY_ID_A   8'h90
`define SF_OP_LEGACY_ID_B   8'hAB

// Default opcodes for commands whose codes the integrator supplies.
`define SF_OP_WR_ENABLE_DEF  8'h06
`define SF_OP_ARM_DEF        8'h50
`define SF_OP_STAT_WRITE_DEF 8'h01
`define SF_OP_SEC_READ_DEF  8'h35

// Identification bytes, arbitrary neutral values.
`define SF_ID_MAKER_DEF     8'hA5
`define SF_ID_TYPE_DEF      8'h5A
`define SF_ID_SIZE_DEF      8'h3C

// Primary status bit positions.
`define SF_BIT_BUSY         0
`define SF_BIT_LATCH        1
`define SF_BIT_LEVEL0       2
`define SF_BIT_LEVEL2       4
`define SF_BIT_AUTO_INC     6
`define SF_BIT_LOCK         7

// Writable masks and reset values.
`define SF_SEC_MASK         8'h03
`define SF_SEC_RESET        8'h00
`define SF_BP_RESET         3'h0
// Pin idle levels {select, clock, data, protect}, so no false edge follows reset.
`define SF_PIN_IDLE         4'h9

// Serial bit counts.
`define SF_LAST_OP_BIT      5'h07
`define SF_LAST_ADDR_BIT    5'h17
`define SF_LAST_OUT_BIT     3'h7
`define SF_BYTE_BITS        5'h08
`define SF_WORD_BITS        5'h10
`define SF_DATA_SAT         5'h11
`define SF_JID_LAST         2'h2

// Register bus map.
`define SF_WB_CTRL          8'h00
`define SF_WB_STATUS        8'h04
`define SF_CTRL_START       0
`define SF_CTRL_AUTO_INC    1

// Program time and clock period.
`define SF_PROG_TIME_NS     10000
`define SF_CLK_PERIOD_NS    4
`define SF_PROG_CYCLES      (`SF_PROG_TIME_NS / `SF_CLK_PERIOD_NS)

`endif

//--- core/spi_flash_pkg.sv
// Types shared by the serial flash command block.
package spi_flash_pkg;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
    } pins_type;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_OUT, ST_SKIP
    } state_type;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_WR_ENABLE, CMD_WR_DISABLE, CMD_ARM, CMD_STAT_WRITE
    } cmd_type;

    typedef enum logic [1:0] {
        OUT_PRI, OUT_SEC, OUT_JID, OUT_LID
    } out_type;

endpackage : spi_flash_pkg

//--- core/spi_flash_status_id.sv
// Serial flash status, write-enable, status-write and identification commands.
//
// Overview of operation
// (R1) Status read is accepted anytime, even while busy, showing live busy.
// (R2) Status read repeats the status byte until chip select rises.
// (R3) Secondary status read repeats the secondary byte until chip select rises.
// (R4) Host holds chip select low through opcode and all wanted status data.
// (R5) Write enable sets the write latch flag to one.
// (R6) Host sends write enable before program, erase, or instead of arming.
// (R7) A completed status write clears the write latch at chip select rise.
// (R8) Enable, disable, arm and status write act only at chip select rise.
// (R9) Write disable clears write latch and auto-increment flags.
// (R10) Write disable never aborts a running program operation.
// (R11) Arming opens status only for the immediately following status write.
// (R12) A one-byte status write updates protect level and lock bits.
// (R13) Status write is ignored while protect pin low and lock bit set.
// (R14) With protect pin low the lock bit may go 0 to 1, never back.
// (R15) With protect pin high all protection bits are writable.
// (R16) Unlocked status write may set lock and change levels together.
// (R17) A two-byte status write loads primary then secondary status.
// (R18) Only an exact byte or word of status data is executed.
// (R19) Standard ID sends maker byte, then memory type and capacity.
// (R20) Standard ID output ends whenever chip select rises.
// (R21) Legacy ID is decoded under two opcodes, then a 24-bit address.
// (R22) Legacy ID alternates maker and device codes until chip select rises.
// (R23) Write disable decodes as 04 and status read as 05.
// (R24) Other opcodes are parameters with integrator defaults; the code keeps the ID opcodes 9F, 90 and AB fixed.
// (R25) Address bit zero picks which legacy ID code comes first.
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "spi_flash_params.svh"
`default_nettype none

module spi_flash_status_id #(
    parameter logic [7:0] WRITE_ENABLE_OP = `SF_OP_WR_ENABLE_DEF,
    parameter logic [7:0] ARM_OP          = `SF_OP_ARM_DEF,
    parameter logic [7:0] STATUS_WRITE_OP = `SF_OP_STAT_WRITE_DEF,
    parameter logic [7:0] SEC_READ_OP     = `SF_OP_SEC_READ_DEF,
    parameter logic [7:0] ID_MAKER        = `SF_ID_MAKER_DEF,
    parameter logic [7:0] ID_TYPE         = `SF_ID_TYPE_DEF,
    parameter logic [7:0] ID_SIZE         = `SF_ID_SIZE_DEF
) (
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    // Serial pins
    input  wire logic        chip_select_n_i,
    input  wire logic        sck_i,
    input  wire logic        si_i,
    input  wire logic        protect_pin_n_i,
    output var  logic        so_o,
    output var  logic        so_oe_o
);

    spi_flash_pkg::pins_type  meta_reg;
    spi_flash_pkg::pins_type  sync_reg;
    logic                     sck_d_reg;
    logic                     cs_d_reg;
    spi_flash_pkg::state_type state_reg;
    spi_flash_pkg::cmd_type   cmd_reg;
    spi_flash_pkg::out_type   omode_reg;
    logic [4:0]               bitcnt_reg;
    logic [7:0]               shin_reg;
    logic [15:0]              din_reg;
    logic [4:0]               dbits_reg;
    logic [7:0]               osh_reg;
    logic [2:0]               ocnt_reg;
    logic [1:0]               idx_reg;
    logic                     so_reg;
    logic                     so_oe_reg;
    logic                     latch_reg;
    logic                     auto_inc_reg;
    logic [2:0]               bp_reg;
    logic                     lock_reg;
    logic [7:0]               sec_reg;
    logic                     arm_reg;
    logic                     busy_reg;
    logic [11:0]              busy_cnt_reg;
    logic                     ack_reg;
    logic [31:0]              dat_reg;

    logic                     sck_rise;
    logic                     sck_fall;
    logic                     cs_rise;
    logic                     cs_fall;
    logic [7:0]               shin_next;
    logic [7:0]               pri_status;
    logic                     wr_len_ok;
    logic                     wr_ok;
    logic                     wb_hit;
    logic                     prog_start;

    // Pins cross into the clock domain through two flip-flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= `SF_PIN_IDLE;
            sync_reg <= `SF_PIN_IDLE;
        end else begin
            meta_reg <= {chip_select_n_i, sck_i, si_i, protect_pin_n_i};
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_d_reg <= 1'b0;
            cs_d_reg  <= 1'b1;
        end else begin
            sck_d_reg <= sync_reg.sck;
            cs_d_reg  <= sync_reg.cs_n;
        end
    end

    assign sck_rise  = sync_reg.sck & ~sck_d_reg & ~sync_reg.cs_n;
    assign sck_fall  = ~sync_reg.sck & sck_d_reg & ~sync_reg.cs_n;
    assign cs_rise   = sync_reg.cs_n & ~cs_d_reg;
    assign cs_fall   = ~sync_reg.cs_n & cs_d_reg;
    assign shin_next = {shin_reg[6:0], sync_reg.si};

    // (R1) Live busy
    assign pri_status = {lock_reg, auto_inc_reg, 1'b0, bp_reg, latch_reg, busy_reg};

    function automatic logic [7:0] out_byte(
        input spi_flash_pkg::out_type mode,
        input logic [1:0]             idx,
        input logic [7:0]             pri,
        input logic [7:0]             sec
    );
        logic [7:0] b;
        b = pri;
        case (mode)
            spi_flash_pkg::OUT_PRI: b = pri;
            spi_flash_pkg::OUT_SEC: b = sec;
            // (R19) Maker then device
            spi_flash_pkg::OUT_JID: begin
                if (idx == 2'h0) begin
                    b = ID_MAKER;
                end else if (idx == 2'h1) begin
                    b = ID_TYPE;
                end else begin
                    b = ID_SIZE;
                end
            end
            // (R22) Legacy code pair
            spi_flash_pkg::OUT_LID: b = idx[0] ? ID_SIZE : ID_MAKER;
            default: b = pri;
        endcase
        return b;
    endfunction : out_byte

    function automatic logic [1:0] next_idx(
        input spi_flash_pkg::out_type mode,
        input logic [1:0]             idx
    );
        logic [1:0] n;
        n = idx;
        if (mode == spi_flash_pkg::OUT_LID) begin
            n = {1'b0, ~idx[0]};
        end else if (mode == spi_flash_pkg::OUT_JID) begin
            n = (idx == `SF_JID_LAST) ? 2'h0 : idx + 2'h1;
        end
        return n;
    endfunction : next_idx

    // Command framing and decode; framing ends on every chip select rise.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg  <= spi_flash_pkg::ST_IDLE;
            cmd_reg    <= spi_flash_pkg::CMD_NONE;
            omode_reg  <= spi_flash_pkg::OUT_PRI;
            bitcnt_reg <= 5'h00;
            shin_reg   <= 8'h00;
            din_reg    <= 16'h0000;
            dbits_reg  <= 5'h00;
            osh_reg    <= 8'h00;
            ocnt_reg   <= 3'h0;
            idx_reg    <= 2'h0;
        end else if (sync_reg.cs_n) begin
            // (R20) Output ends
            state_reg <= spi_flash_pkg::ST_IDLE;
            if (!cs_rise) begin
                cmd_reg <= spi_flash_pkg::CMD_NONE;
            end
        end else if (cs_fall) begin
            state_reg  <= spi_flash_pkg::ST_OPCODE;
            cmd_reg    <= spi_flash_pkg::CMD_NONE;
            bitcnt_reg <= 5'h00;
            dbits_reg  <= 5'h00;
        end else if (sck_rise) begin
            shin_reg   <= shin_next;
            bitcnt_reg <= bitcnt_reg + 5'h01;
            case (state_reg)
                spi_flash_pkg::ST_OPCODE: begin
                    if (bitcnt_reg == `SF_LAST_OP_BIT) begin
                        bitcnt_reg <= 5'h00;
                        ocnt_reg   <= 3'h0;
                        state_reg  <= spi_flash_pkg::ST_SKIP;
                        // (R23) Fixed opcodes
                        if (shin_next == `SF_OP_STATUS_READ) begin
                            // (R2) Status repeat
                            state_reg <= spi_flash_pkg::ST_OUT;
                            omode_reg <= spi_flash_pkg::OUT_PRI;
                            osh_reg   <= pri_status;
                        end else if (shin_next == `SF_OP_WRITE_DISABLE) begin
                            cmd_reg <= spi_flash_pkg::CMD_WR_DISABLE;
                        // (R24) Parameter opcodes
                        end else if (shin_next == SEC_READ_OP) begin
                            // (R3) Secondary repeat
                            state_reg <= spi_flash_pkg::ST_OUT;
                            omode_reg <= spi_flash_pkg::OUT_SEC;
                            osh_reg   <= sec_reg;
                        end else if (shin_next == WRITE_ENABLE_OP) begin
                            cmd_reg <= spi_flash_pkg::CMD_WR_ENABLE;
                        end else if (shin_next == ARM_OP) begin
                            cmd_reg <= spi_flash_pkg::CMD_ARM;
                        end else if (shin_next == STATUS_WRITE_OP) begin
                            cmd_reg   <= spi_flash_pkg::CMD_STAT_WRITE;
                            state_reg <= spi_flash_pkg::ST_DATA;
                        end else if (shin_next == `SF_OP_JEDEC_ID) begin
                            state_reg <= spi_flash_pkg::ST_OUT;
                            omode_reg <= spi_flash_pkg::OUT_JID;
                            osh_reg   <= ID_MAKER;
                            idx_reg   <= 2'h1;
                        // (R21) Two legacy opcodes
                        end else if (shin_next == `SF_OP_LEGACY_ID_A ||
                                     shin_next == `SF_OP_LEGACY_ID_B) begin
                            state_reg <= spi_flash_pkg::ST_ADDR;
                            omode_reg <= spi_flash_pkg::OUT_LID;
                        end
                    end
                end
                spi_flash_pkg::ST_ADDR: begin
                    if (bitcnt_reg == `SF_LAST_ADDR_BIT) begin
                        // (R25) Address bit zero
                        state_reg <= spi_flash_pkg::ST_OUT;
                        osh_reg   <= shin_next[0] ? ID_SIZE : ID_MAKER;
                        idx_reg   <= {1'b0, ~shin_next[0]};
                    end
                end
                spi_flash_pkg::ST_DATA: begin
                    din_reg <= {din_reg[14:0], sync_reg.si};
                    // (R18) Surplus counted
                    if (dbits_reg != `SF_DATA_SAT) begin
                        dbits_reg <= dbits_reg + 5'h01;
                    end
                end
                spi_flash_pkg::ST_IDLE,
                spi_flash_pkg::ST_OUT,
                spi_flash_pkg::ST_SKIP: begin
                end
                default: state_reg <= spi_flash_pkg::ST_SKIP;
            endcase
        end else if (sck_fall && state_reg == spi_flash_pkg::ST_OUT) begin
            ocnt_reg <= ocnt_reg + 3'h1;
            if (ocnt_reg == `SF_LAST_OUT_BIT) begin
                osh_reg <= out_byte(omode_reg, idx_reg, pri_status, sec_reg);
                idx_reg <= next_idx(omode_reg, idx_reg);
            end else begin
                osh_reg <= {osh_reg[6:0], 1'b0};
            end
        end
    end

    // Data out changes on the falling clock so the host samples on the rise.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            so_reg    <= 1'b0;
            so_oe_reg <= 1'b0;
        end else if (sync_reg.cs_n) begin
            so_oe_reg <= 1'b0;
        end else if (sck_fall && state_reg == spi_flash_pkg::ST_OUT) begin
            so_reg    <= osh_reg[7];
            so_oe_reg <= 1'b1;
        end
    end

    assign so_o    = so_reg;
    assign so_oe_o = so_oe_reg;

    // (R18) Exact length only
    assign wr_len_ok = (dbits_reg == `SF_BYTE_BITS) || (dbits_reg == `SF_WORD_BITS);
    // (R13) Locked write ignored
    assign wr_ok = (cmd_reg == spi_flash_pkg::CMD_STAT_WRITE) && (arm_reg || latch_reg) &&
                   !(!sync_reg.wp_n && lock_reg) && wr_len_ok;

    assign wb_hit     = wb_cyc_i && wb_stb_i && !ack_reg;
    assign prog_start = wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `SF_WB_CTRL &&
                        wb_dat_i[`SF_CTRL_START] && latch_reg && !busy_reg;

    // Status bits; command effects wait for chip select rise.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_reg    <= 1'b0;
            auto_inc_reg <= 1'b0;
            bp_reg       <= `SF_BP_RESET;
            lock_reg     <= 1'b0;
            sec_reg      <= `SF_SEC_RESET;
            arm_reg      <= 1'b0;
        end else begin
            if (prog_start) begin
                latch_reg <= 1'b0;
            end
            if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `SF_WB_CTRL &&
                wb_dat_i[`SF_CTRL_AUTO_INC] && latch_reg) begin
                auto_inc_reg <= 1'b1;
            end
            // (R8) Act at rise
            if (cs_rise) begin
                // (R11) Arm only next
                arm_reg <= (cmd_reg == spi_flash_pkg::CMD_ARM);
                case (cmd_reg)
                    // (R5) Set latch
                    spi_flash_pkg::CMD_WR_ENABLE: latch_reg <= 1'b1;
                    // (R9) Clear both
                    spi_flash_pkg::CMD_WR_DISABLE: begin
                        latch_reg    <= 1'b0;
                        auto_inc_reg <= 1'b0;
                    end
                    spi_flash_pkg::CMD_STAT_WRITE: begin
                        if (wr_ok) begin
                            // (R7) Latch cleared
                            latch_reg <= 1'b0;
                            // (R12) Byte fields
                            // (R14) Lock set only
                            // (R15) Pin high writable
                            // (R16) Lock with levels
                            if (dbits_reg == `SF_WORD_BITS) begin
                                bp_reg   <= din_reg[`SF_BIT_LEVEL2+8:`SF_BIT_LEVEL0+8];
                                lock_reg <= din_reg[`SF_BIT_LOCK+8];
                                // (R17) Second byte
                                sec_reg  <= din_reg[7:0] & `SF_SEC_MASK;
                            end else begin
                                bp_reg   <= din_reg[`SF_BIT_LEVEL2:`SF_BIT_LEVEL0];
                                lock_reg <= din_reg[`SF_BIT_LOCK];
                            end
                        end
                    end
                    spi_flash_pkg::CMD_NONE,
                    spi_flash_pkg::CMD_ARM: begin
                    end
                    default: arm_reg <= 1'b0;
                endcase
            end
        end
    end

    // Busy timer; limited to one program length and untouched by disable.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_reg     <= 1'b0;
            busy_cnt_reg <= 12'h000;
        end else if (prog_start) begin
            busy_reg     <= 1'b1;
            busy_cnt_reg <= 12'(`SF_PROG_CYCLES);
        end else if (busy_reg) begin
            // (R10) Runs to end
            busy_cnt_reg <= busy_cnt_reg - 12'h001;
            busy_reg     <= (busy_cnt_reg != 12'h001);
        end
    end

    // Wishbone answers one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_hit;
            dat_reg <= 32'h0000_0000;
            if (wb_hit && !wb_we_i) begin
                if (wb_adr_i == `SF_WB_STATUS) begin
                    dat_reg <= {16'h0000, sec_reg, pri_status};
                end else if (wb_adr_i == `SF_WB_CTRL) begin
                    dat_reg <= {30'h0000_0000, auto_inc_reg, busy_reg};
                end
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    default clocking def_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    enable_sets_latch_a: assert property ( // (R5)
        cs_rise && cmd_reg == spi_flash_pkg::CMD_WR_ENABLE |=> latch_reg)
        else $error("Write enable did not set the latch.");

    disable_clears_a: assert property ( // (R9)
        cs_rise && cmd_reg == spi_flash_pkg::CMD_WR_DISABLE && !prog_start
        |=> !latch_reg && !auto_inc_reg)
        else $error("Write disable left a flag set.");

    locked_ignored_a: assert property ( // (R13)
        cs_rise && cmd_reg == spi_flash_pkg::CMD_STAT_WRITE && !sync_reg.wp_n && lock_reg
        |=> lock_reg && $stable(bp_reg) && $stable(sec_reg))
        else $error("Locked status was written.");

    write_clears_latch_a: assert property ( // (R7)
        cs_rise && wr_ok |=> !latch_reg && (lock_reg == $past(din_reg[`SF_BIT_LOCK]) ||
        $past(dbits_reg) == `SF_WORD_BITS))
        else $error("Status write did not complete.");

    partial_refused_a: assert property ( // (R18)
        cs_rise && cmd_reg == spi_flash_pkg::CMD_STAT_WRITE && !wr_len_ok
        |=> $stable(bp_reg) && $stable(lock_reg) && $stable(sec_reg))
        else $error("Partial status data was executed.");

    arm_one_shot_a: assert property ( // (R11)
        cs_rise && cmd_reg != spi_flash_pkg::CMD_ARM |=> !arm_reg)
        else $error("Arming survived another command.");

    busy_survives_a: assert property ( // (R10)
        busy_reg && busy_cnt_reg > 12'h002 && cs_rise &&
        cmd_reg == spi_flash_pkg::CMD_WR_DISABLE
        |=> busy_reg ##1 busy_reg)
        else $error("Write disable aborted a program.");

    output_ends_a: assert property ( // (R20)
        cs_rise |=> state_reg == spi_flash_pkg::ST_IDLE && !so_oe_reg)
        else $error("Output continued after chip select rise.");

    ack_single_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge held too long.");

endmodule : spi_flash_status_id

`default_nettype wire

//--- test/spi_host_model.sv
// Host controller model that drives the serial pins in mode 0.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // Clock and serial return
    input  wire logic clk_i,
    input  wire logic so_i,
    // Serial drive
    output var  logic cs_n_o,
    output var  logic sck_o,
    output var  logic si_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end
    // The clock stands still outside frames, so stray edges never reach the device.
    task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        cs_n_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        for (int b = 63; b > 63 - n; b--) begin
            si_o <= tx[b];
            repeat (8) @(posedge clk_i);
            sck_o <= 1'b1;
            rx = {rx[62:0], so_i};
            repeat (8) @(posedge clk_i);
            sck_o <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
        cs_n_o <= 1'b1;
        si_o   <= ~si_o;
        repeat (16) @(posedge clk_i);
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

//--- test/tb_spi_flash_status_id.sv
// Self-checking bench for the status and identification command block.
`timescale 1ns/1ps
`include "spi_flash_params.svh"
`default_nettype none
module tb_spi_flash_status_id;
    localparam logic [7:0] ID_M = `SF_ID_MAKER_DEF;
    localparam logic [7:0] ID_T = `SF_ID_TYPE_DEF;
    localparam logic [7:0] ID_S = `SF_ID_SIZE_DEF;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0;
    logic        wp_n = 1'b1;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        cs_n, sck, si, so_o, so_oe_o;
    logic [63:0] rx;
    logic [31:0] rd;
    int          k;
    int          failures = 0;
    int          num_checks = 0;
    always #2 clk_i = ~clk_i;
    spi_flash_status_id spi_flash_status_id_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chip_select_n_i(cs_n), .sck_i(sck),
        .si_i(si), .protect_pin_n_i(wp_n), .so_o(so_o), .so_oe_o(so_oe_o));
    spi_host_model spi_host_model_i (
        .clk_i(clk_i), .so_i(so_o), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= a;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
        @(posedge clk_i);
    endtask : wb
    task automatic op(input logic [7:0] o);
        spi_host_model_i.frame({o, 56'h0}, 8, rx);
    endtask : op
    task automatic sr(input logic [7:0] o, input logic [7:0] exp);
        spi_host_model_i.frame({o, 56'h0}, 24, rx);
        chk({16'h0, rx[15:0]}, {16'h0, exp, exp});
    endtask : sr
    task automatic status_write_cmd(input logic [7:0] pre, input logic [15:0] d, input int n);
        op(pre);
        spi_host_model_i.frame({8'h01, d, 40'h0}, 8 + n, rx);
    endtask : status_write_cmd
    task automatic scn_idle_reads;
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
    endtask : scn_idle_reads
    task automatic scn_enable_write;
        op(8'h06);
        sr(8'h05, 8'h02);
        spi_host_model_i.frame({8'h01, 8'h88, 48'h0}, 16, rx);
        sr(8'h05, 8'h88);
    endtask : scn_enable_write
    task automatic scn_lock_pin;
        wp_n <= 1'b0;
        status_write_cmd(8'h50, 16'h0000, 8);
        sr(8'h05, 8'h88);
        wp_n <= 1'b1;
        status_write_cmd(8'h50, 16'h0003, 16);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0000_0300);
        sr(8'h35, 8'h03);
    endtask : scn_lock_pin
    task automatic scn_refusals;
        status_write_cmd(8'h50, 16'h0C00, 12);
        sr(8'h05, 8'h00);
        op(8'h50);
        status_write_cmd(8'h05, 16'h0C00, 8);
        sr(8'h05, 8'h00);
        wp_n <= 1'b0;
        status_write_cmd(8'h50, 16'h8400, 8);
        sr(8'h05, 8'h84);
        wp_n <= 1'b1;
        status_write_cmd(8'h50, 16'h0000, 8);
        sr(8'h05, 8'h00);
    endtask : scn_refusals
    task automatic scn_program_busy;
        op(8'h06);
        wb(1'b1, 8'h00, 32'h2);
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h3);
        op(8'h06);
        op(8'h04);
        sr(8'h05, 8'h01);
        k = 0;
        do begin
            wb(1'b0, 8'h00, 32'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 1000);
        chk(rd, 32'h0);
    endtask : scn_program_busy
    task automatic scn_ids;
        spi_host_model_i.frame({8'h9F, 56'h0}, 40, rx);
        chk(rx[31:0], {ID_M, ID_T, ID_S, ID_M});
        spi_host_model_i.frame({8'h9F, 56'h0}, 20, rx);
        chk({20'h0, rx[11:0]}, {20'h0, ID_M, ID_T[7:4]});
        chk({31'h0, so_oe_o}, 32'h0);
        spi_host_model_i.frame({8'h90, 24'h0, 32'h0}, 56, rx);
        chk({8'h0, rx[23:0]}, {8'h0, ID_M, ID_S, ID_M});
        spi_host_model_i.frame({8'hAB, 24'h1, 32'h0}, 48, rx);
        chk({16'h0, rx[15:0]}, {16'h0, ID_S, ID_M});
    endtask : scn_ids
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        scn_idle_reads();
        scn_enable_write();
        scn_lock_pin();
        scn_refusals();
        scn_program_busy();
        scn_ids();
        tally_and_finish();
    end
endmodule : tb_spi_flash_status_id
`default_nettype wire
